// [tpd_pkg.sv]
// Overview of operation
// - With averaging on, take 4, 8 or 16 conversions per type, per-type depth.
// - Panel depths come from register panel_average_depth, auxiliary depth from aux_input_config.
// - Median filter drops top and bottom quarter, averages the middle half.
// - Mean filter averages every collected sample, none discarded.
// - Register operating_mode_config picks filter type and position and pressure averaging.
// - Combined command runs X,Y or X,Y,Z1 or X,Y,Z1,Z2 in order.
// - Each panel result is a 16-bit word: 12 data, 2 type tag, 2 event tag; the aux result has 4 zero bits in 3:0.
// - Data high down to bit 4, type in 3:2, event in 1:0; 8-bit zero-fills.
// - Reading a result still pending returns FFFFh, event tag 11b.
// - Combined command holds all its locations at FFFFh until fully tagged.
// - One location per type, no FIFO; a newer result overwrites the older.
// - All-off idle disables everything incl. pullups until next host command.
// - Touch-watch idle enables only the pullup; no timer runs there.
// - Direct mode accepts setup, measure and combined commands.
// - Level and edge interrupt modes steer touch_irq_n and the idle return.
// - Level mode: idle watching, irq low on touch, held through measuring.
// - Level mode without hold: check touch for touch_check_timing time, tag, then readable.
// - Level mode: back to watch, irq follows touch presence afterwards.
// - Edge mode, touch present: tag 00 initial or 01 midpress, then all-off.
// - Edge mode, no touch: tag 10, watch idle, irq only on new touch.
package tpd_pkg;
  localparam int ADC_W = 12;
  localparam int NUM_LOC = 5;
  localparam logic [6:0] ADDR_STATUS = 7'h00;
  localparam logic [6:0] ADDR_AVG = 7'h03;
  localparam logic [6:0] ADDR_CHK = 7'h07;
  localparam logic [6:0] ADDR_AUXCFG = 7'h0A;
  localparam logic [6:0] ADDR_MODE = 7'h0B;
  localparam logic [6:0] ADDR_RES = 7'h52;
  localparam logic [2:0] LOC_X = 3'h0;
  localparam logic [2:0] LOC_AUX = 3'h4;
  localparam logic [4:0] CMD_SETUP = 5'h0D;
  localparam logic [4:0] CMD_COMB = 5'h0E;
  localparam logic [4:0] CMD_MEAS = 5'h0F;
  localparam logic [1:0] COMB_AUX = 2'h3;
  localparam int MODE_MED = 0;
  localparam int MODE_POS = 1;
  localparam int MODE_PRES = 2;
  localparam int MODE_EDGE = 3;
  localparam int MODE_RES8 = 4;
  localparam logic [1:0] TOUCH_EVENT_TAG_TOUCH = 2'h0;
  localparam logic [1:0] TOUCH_EVENT_TAG_MID = 2'h1;
  localparam logic [1:0] TOUCH_EVENT_TAG_REL = 2'h2;
  localparam logic [15:0] WORD_BUSY = 16'hFFFF;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [3:0] SYNC_RST = 4'h2;
  localparam int SY_SCLK = 0;
  localparam int SY_CSN = 1;
  localparam int SY_MOSI = 2;
  localparam int SY_TCH = 3;
  localparam logic [4:0] BIT_BYTE = 5'h07;
  localparam logic [4:0] BIT_WORD = 5'h0F;
  localparam logic [4:0] BIT_MAX = 5'h1F;
  localparam int CLK_NS = 25;
  localparam int CHK_UNIT_NS = 1000;
  localparam int CHK_UNIT_CYC = (CHK_UNIT_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [7:0] {
    ST_OFF = 8'h01, ST_WATCH = 8'h02, ST_SETUP = 8'h04, ST_CONV = 8'h08,
    ST_WAIT = 8'h10, ST_SCAN = 8'h20, ST_FIN = 8'h40, ST_CHECK = 8'h80
  } tpd_state_t;

  // Depth code to log2 of sample count
  function automatic logic [2:0] tpd_depth_log(input logic [1:0] code);
    case (code)
      2'h1: tpd_depth_log = 3'h2;
      2'h2: tpd_depth_log = 3'h3;
      2'h3: tpd_depth_log = 3'h4;
      default: tpd_depth_log = 3'h0;
    endcase
  endfunction

  // Result word assembly
  function automatic logic [15:0] tpd_word(input logic [ADC_W-1:0] raw,
      input logic [2:0] loc, input logic [1:0] touch_event_tag, input logic res8);
    logic [ADC_W-1:0] d;
    d = res8 ? {raw[ADC_W-1:4], 4'h0} : raw;
    if (loc == LOC_AUX) tpd_word = {d, 4'h0};
    else tpd_word = {d, loc[1:0], touch_event_tag};
  endfunction
endpackage

// [tpd_mem_if.sv]
`timescale 1ns/1ps
interface tpd_mem_if #(parameter int AW = 4, parameter int DW = 12);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr,
    input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
    output rdata);
endinterface

// [tpd_samp_mem.sv]
`timescale 1ns/1ps
module tpd_samp_mem #(
  parameter int AW = 4,
  parameter int DW = 12
) (
  // Clock
  input wire logic clk_sys,
  // Memory port
  tpd_mem_if.mem m
);
  logic [DW-1:0] mem_r [2**AW];

  // Sample store
  always_ff @(posedge clk_sys) begin
    if (m.we) begin
      mem_r[m.waddr] <= m.wdata;
    end
  end

  // Registered read
  always_ff @(posedge clk_sys) begin
    m.rdata <= mem_r[m.raddr];
  end
endmodule

// [tpd_ctrl.sv]
`timescale 1ns/1ps
module tpd_ctrl
  import tpd_pkg::*;
#(
  parameter int MAX_SAMP = 16
) (
  // System
  input wire logic clk_sys,
  input wire logic resetn,
  // Serial host port
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Touch interrupt
  output logic touch_irq_n,
  // Front end
  input wire logic touch_det,
  input wire logic adc_done,
  input wire logic [ADC_W-1:0] adc_data,
  output logic adc_start,
  output logic pullup_en,
  output logic panel_drive_en,
  output logic [2:0] panel_sel
);
  localparam int AW = $clog2(MAX_SAMP);
  localparam int SW = ADC_W + AW;

  logic [3:0] sync1_r, sync2_r;
  logic sclk_d_r, sclk_rise, sclk_fall, cs_n_s, mosi_s, tch_s;
  logic [4:0] bit_cnt_r;
  logic [7:0] rx_sh_r, byte0_r, rx_byte, cmd_r, status;
  logic [15:0] tx_sh_r, rd_word;
  logic byte_done, word_done, wr_pulse, cmd_v_r;
  logic [6:0] rd_addr, loc_off;
  logic [7:0] avg_r, chk_r, auxcfg_r, mode_r;
  tpd_state_t st_r, st_nxt, cmd_tgt;
  logic [2:0] cur_r, last_r, start_loc, last_loc, cur_nlog, pass_r, k_m1;
  logic hold_r, hold_cmd, seq_r, is_start, tag_now, do_med, edge_m;
  logic [AW:0] cnt_r, idx_r, n_m1;
  logic [SW-1:0] sum_r;
  logic [MAX_SAMP-1:0] rem_r;
  logic rdv_r, have_r, pass_end, chk_done;
  logic [AW-1:0] ridx_r, maxi_r, mini_r;
  logic [ADC_W-1:0] maxv_r, minv_r, res_val;
  logic [7:0] chk_cnt_r;
  logic [6:0] unit_r;
  logic [1:0] touch_event_tag;
  logic [NUM_LOC-1:0] pend_r, req_r;
  logic [ADC_W-1:0] raw_r [NUM_LOC];
  logic [15:0] word_r [NUM_LOC];
  logic [15:0] loc_view [NUM_LOC];
  logic irq_n_r, pullup_r, drive_r, start_r, miso_r, miso_oe_r;
  logic [2:0] sel_r;

  tpd_mem_if #(.AW(AW), .DW(ADC_W)) mif ();
  tpd_samp_mem #(.AW(AW), .DW(ADC_W)) u_mem (.clk_sys(clk_sys), .m(mif));

  function automatic logic fn_is_cmd(input logic [7:0] b);
    fn_is_cmd = (b[7:3] == CMD_SETUP) || (b[7:3] == CMD_COMB) ||
                (b[7:3] == CMD_MEAS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
      sclk_d_r <= 1'b0;
    end else begin
      sync1_r <= {touch_det, mosi, cs_n, sclk};
      sync2_r <= sync1_r;
      sclk_d_r <= sync2_r[SY_SCLK];
    end
  end
  assign cs_n_s = sync2_r[SY_CSN];
  assign mosi_s = sync2_r[SY_MOSI];
  assign tch_s = sync2_r[SY_TCH];
  assign sclk_rise = sync2_r[SY_SCLK] && !sclk_d_r && !cs_n_s;
  assign sclk_fall = !sync2_r[SY_SCLK] && sclk_d_r && !cs_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Serial host port
  assign rx_byte = {rx_sh_r[6:0], mosi_s};
  assign byte_done = sclk_rise && (bit_cnt_r == BIT_BYTE);
  assign word_done = sclk_rise && (bit_cnt_r == BIT_WORD);
  assign wr_pulse = word_done && !fn_is_cmd(byte0_r) && !byte0_r[0];
  assign rd_addr = rx_byte[7:1];
  assign loc_off = rd_addr - ADDR_RES;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_r <= '0;
      rx_sh_r <= '0;
      byte0_r <= '0;
    end else if (cs_n_s) begin
      bit_cnt_r <= '0;
    end else if (sclk_rise) begin
      rx_sh_r <= rx_byte;
      if (bit_cnt_r != BIT_MAX) bit_cnt_r <= bit_cnt_r + 5'h01;
      if (byte_done) byte0_r <= rx_byte;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmd_v_r <= 1'b0;
      cmd_r <= '0;
    end else begin
      cmd_v_r <= byte_done && fn_is_cmd(rx_byte);
      if (byte_done) cmd_r <= rx_byte;
    end
  end

  always_comb begin
    status = {st_r != ST_OFF && st_r != ST_WATCH && st_r != ST_SETUP,
              tch_s, !irq_n_r, pend_r};
    rd_word = '0;
    if (rd_addr == ADDR_STATUS) rd_word = {status, 8'h00};
    else if (rd_addr == ADDR_AVG) rd_word = {avg_r, 8'h00};
    else if (rd_addr == ADDR_CHK) rd_word = {chk_r, 8'h00};
    else if (rd_addr == ADDR_AUXCFG) rd_word = {auxcfg_r, 8'h00};
    else if (rd_addr == ADDR_MODE) rd_word = {mode_r, 8'h00};
    else if (rd_addr >= ADDR_RES && loc_off < 7'(NUM_LOC))
      rd_word = loc_view[loc_off[2:0]];
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_sh_r <= '0;
      miso_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      miso_oe_r <= !cs_n_s;
      if (byte_done && !fn_is_cmd(rx_byte) && rx_byte[0]) begin
        tx_sh_r <= rd_word;
      end else if (sclk_fall) begin
        tx_sh_r <= {tx_sh_r[14:0], 1'b0};
      end
      if (cs_n_s) miso_r <= 1'b0;
      else if (sclk_fall) miso_r <= tx_sh_r[15];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      avg_r <= CFG_RST;
      chk_r <= CFG_RST;
      auxcfg_r <= CFG_RST;
      mode_r <= CFG_RST;
    end else if (wr_pulse) begin
      if (byte0_r[7:1] == ADDR_AVG) avg_r <= rx_byte;
      else if (byte0_r[7:1] == ADDR_CHK) chk_r <= rx_byte;
      else if (byte0_r[7:1] == ADDR_AUXCFG) auxcfg_r <= rx_byte;
      else if (byte0_r[7:1] == ADDR_MODE) mode_r <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and sequencing
  assign edge_m = mode_r[MODE_EDGE];

  always_comb begin
    start_loc = {1'b0, cmd_r[2:1]};
    last_loc = {1'b0, cmd_r[2:1]};
    hold_cmd = cmd_r[0];
    cmd_tgt = ST_CONV;
    if (cmd_r[7:3] == CMD_SETUP) begin
      cmd_tgt = ST_SETUP;
      hold_cmd = 1'b1;
    end else if (cmd_r[7:3] == CMD_COMB) begin
      hold_cmd = 1'b0;
      if (cmd_r[2:1] == COMB_AUX) begin
        start_loc = LOC_AUX;
        last_loc = LOC_AUX;
      end else begin
        start_loc = LOC_X;
        last_loc = {1'b0, cmd_r[2:1]} + 3'h1;
      end
    end
    if (st_r == ST_SETUP && cmd_r[7:3] != CMD_SETUP &&
        (cmd_r[7:3] != CMD_MEAS || start_loc != cur_r)) cmd_tgt = ST_OFF;
  end

  // Depth and filter for the type in progress
  always_comb begin
    cur_nlog = 3'h0;
    if (cur_r == LOC_AUX) cur_nlog = tpd_depth_log(auxcfg_r[1:0]);
    else if (cur_r[1] ? mode_r[MODE_PRES] : mode_r[MODE_POS])
      cur_nlog = tpd_depth_log(avg_r[2*cur_r[1:0] +: 2]);
  end
  assign n_m1 = (AW+1)'((1 << cur_nlog) - 1);
  assign k_m1 = 3'((1 << (cur_nlog - 3'h2)) - 1);
  assign do_med = mode_r[MODE_MED] && (cur_nlog != 3'h0);
  assign res_val = do_med ? ADC_W'(sum_r >> (cur_nlog - 3'h1))
                          : ADC_W'(sum_r >> cur_nlog);
  assign pass_end = (st_r == ST_SCAN) && (idx_r > n_m1) && !rdv_r;
  assign chk_done = (st_r == ST_CHECK) && (unit_r == '0) && (chk_cnt_r == '0);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_OFF, ST_WATCH, ST_SETUP: if (cmd_v_r) st_nxt = cmd_tgt;
      ST_CONV: st_nxt = ST_WAIT;
      ST_WAIT: if (adc_done) begin
        if (cnt_r != n_m1) st_nxt = ST_CONV;
        else st_nxt = do_med ? ST_SCAN : ST_FIN;
      end
      ST_SCAN: if (pass_end && pass_r == k_m1) st_nxt = ST_FIN;
      ST_FIN: begin
        if (cur_r != last_r) st_nxt = ST_CONV;
        else if (hold_r) st_nxt = ST_SETUP;
        else if (cur_r == LOC_AUX) st_nxt = (edge_m && seq_r) ? ST_OFF
                                                              : ST_WATCH;
        else st_nxt = ST_CHECK;
      end
      ST_CHECK: if (chk_done) begin
        st_nxt = (edge_m && tch_s) ? ST_OFF : ST_WATCH;
      end
      default: st_nxt = ST_WATCH;
    endcase
  end
  assign is_start = cmd_v_r && (cmd_tgt == ST_CONV) &&
    (st_r == ST_OFF || st_r == ST_WATCH || st_r == ST_SETUP);
  assign tag_now = chk_done || (st_r == ST_FIN && cur_r == last_r &&
    (hold_r || cur_r == LOC_AUX));

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_WATCH;
      cur_r <= LOC_X;
      last_r <= LOC_X;
      hold_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (cmd_v_r &&
          (st_r == ST_OFF || st_r == ST_WATCH || st_r == ST_SETUP)) begin
        cur_r <= start_loc;
        last_r <= last_loc;
        hold_r <= hold_cmd;
      end else if (st_r == ST_FIN && cur_r != last_r) begin
        cur_r <= cur_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample collection and filtering
  assign mif.we = (st_r == ST_WAIT) && adc_done;
  assign mif.waddr = cnt_r[AW-1:0];
  assign mif.wdata = adc_data;
  assign mif.raddr = idx_r[AW-1:0];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      sum_r <= '0;
    end else if (st_nxt == ST_CONV && st_r != ST_WAIT) begin
      cnt_r <= '0;
      sum_r <= '0;
    end else if (mif.we) begin
      cnt_r <= cnt_r + 1'b1;
      sum_r <= sum_r + SW'(adc_data);
    end else if (pass_end) begin
      sum_r <= sum_r - SW'(maxv_r) - SW'(minv_r);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idx_r <= '0;
      rdv_r <= 1'b0;
      ridx_r <= '0;
      pass_r <= '0;
      rem_r <= '0;
    end else begin
      rdv_r <= (st_r == ST_SCAN) && (idx_r <= n_m1);
      ridx_r <= idx_r[AW-1:0];
      if (st_r != ST_SCAN) begin
        idx_r <= '0;
        pass_r <= '0;
        rem_r <= '0;
      end else if (pass_end) begin
        idx_r <= '0;
        pass_r <= pass_r + 3'h1;
        rem_r[maxi_r] <= 1'b1;
        rem_r[mini_r] <= 1'b1;
      end else if (idx_r <= n_m1) begin
        idx_r <= idx_r + 1'b1;
      end
    end
  end

  // Highest and lowest of the samples still in play
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      have_r <= 1'b0;
      maxv_r <= '0;
      minv_r <= '0;
      maxi_r <= '0;
      mini_r <= '0;
    end else if (st_r != ST_SCAN || pass_end) begin
      have_r <= 1'b0;
    end else if (rdv_r && !rem_r[ridx_r]) begin
      have_r <= 1'b1;
      if (!have_r || mif.rdata > maxv_r) begin
        maxv_r <= mif.rdata;
        maxi_r <= ridx_r;
      end
      if (!have_r || mif.rdata <= minv_r) begin
        minv_r <= mif.rdata;
        mini_r <= ridx_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Touch check timing
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      chk_cnt_r <= '0;
      unit_r <= '0;
    end else if (st_r != ST_CHECK) begin
      chk_cnt_r <= (chk_r == '0) ? '0 : chk_r - 8'h01;
      unit_r <= 7'(CHK_UNIT_CYC - 1);
    end else if (unit_r != '0) begin
      unit_r <= unit_r - 7'h01;
    end else if (chk_cnt_r != '0) begin
      chk_cnt_r <= chk_cnt_r - 8'h01;
      unit_r <= 7'(CHK_UNIT_CYC - 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result locations and tagging
  always_comb begin
    if (!tch_s) touch_event_tag = TOUCH_EVENT_TAG_REL;
    else if (edge_m && seq_r) touch_event_tag = TOUCH_EVENT_TAG_MID;
    else touch_event_tag = TOUCH_EVENT_TAG_TOUCH;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) seq_r <= 1'b0;
    else if (st_r == ST_WATCH) seq_r <= 1'b0;
    else if (tag_now && cur_r != LOC_AUX) seq_r <= edge_m && tch_s;
  end

  generate
    for (genvar i = 0; i < NUM_LOC; i++) begin : g_loc
      localparam logic [2:0] LI = 3'(i);
      assign loc_view[i] = pend_r[i] ? WORD_BUSY : word_r[i];
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          pend_r[i] <= 1'b0;
          req_r[i] <= 1'b0;
          raw_r[i] <= '0;
          word_r[i] <= '0;
        end else begin
          if (is_start) begin
            pend_r[i] <= (LI >= start_loc) && (LI <= last_loc);
            req_r[i] <= (LI >= start_loc) && (LI <= last_loc);
          end else if (tag_now && req_r[i]) begin
            pend_r[i] <= 1'b0;
          end
          if (st_r == ST_FIN && cur_r == LI) raw_r[i] <= res_val;
          if (tag_now && req_r[i]) begin
            word_r[i] <= tpd_word((st_r == ST_FIN && cur_r == LI) ? res_val
              : raw_r[i], LI, touch_event_tag, mode_r[MODE_RES8]);
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and front end drive
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_n_r <= 1'b1;
    end else if (!edge_m) begin
      if (st_r == ST_WATCH) irq_n_r <= !tch_s;
    end else if (cmd_v_r) begin
      irq_n_r <= 1'b1;
    end else if (st_r == ST_WATCH && tch_s) begin
      irq_n_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pullup_r <= 1'b1;
      drive_r <= 1'b0;
      start_r <= 1'b0;
      sel_r <= LOC_X;
    end else begin
      pullup_r <= st_nxt == ST_WATCH || st_nxt == ST_CHECK;
      drive_r <= (st_nxt == ST_SETUP || st_nxt == ST_CONV ||
                  st_nxt == ST_WAIT) && cur_r != LOC_AUX;
      start_r <= st_nxt == ST_CONV;
      sel_r <= cur_r;
    end
  end

  assign touch_irq_n = irq_n_r;
  assign pullup_en = pullup_r;
  assign panel_drive_en = drive_r;
  assign adc_start = start_r;
  assign panel_sel = sel_r;
  assign miso = miso_r;
  assign miso_oe = miso_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_chk_end;
    st_r == ST_CHECK ##1 st_r != ST_CHECK;
  endsequence

  a_samp_count: assert property (mif.we |-> cnt_r <= n_m1)
    else $error("sample count beyond depth");
  a_start_pend: assert property (is_start |=> pend_r[cur_r])
    else $error("started location not pending");
  a_comb_held: assert property (
    st_r == ST_CHECK |-> (pend_r & req_r) == req_r)
    else $error("combined location released early");
  a_tag_release: assert property (
    s_chk_end |-> (pend_r & req_r) == '0)
    else $error("locations untagged after check");
  a_off_quiet: assert property (
    st_r == ST_OFF |-> !pullup_en && !adc_start)
    else $error("activity in all-off idle");
  a_watch_only: assert property (
    st_r == ST_WATCH ##1 st_r == ST_WATCH
    |-> pullup_en && !panel_drive_en && !adc_start)
    else $error("watch idle not pullup only");
  a_level_hold: assert property (
    !edge_m && !wr_pulse && !irq_n_r && st_r != ST_WATCH |=> !irq_n_r)
    else $error("level irq released while busy");
  a_level_follow: assert property (
    !edge_m && !wr_pulse && st_r == ST_WATCH |=> irq_n_r == !$past(tch_s))
    else $error("level irq not following touch");
  a_edge_hiz: assert property (
    chk_done && edge_m && tch_s |=> st_r == ST_OFF)
    else $error("edge mode touch not parked");
  a_edge_rel: assert property (
    chk_done && edge_m && !tch_s
    |=> st_r == ST_WATCH ##1 irq_n_r || $past(tch_s))
    else $error("edge release not watching");
  a_edge_cmd_clr: assert property (
    edge_m && cmd_v_r |=> irq_n_r)
    else $error("edge irq not released by command");
endmodule

// [tpd_host.sv]
`timescale 1ns/1ps
module tpd_host (
  // Clock
  input wire logic clk_sys,
  // Serial lines
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One frame, MSB first; sclk stands still between frames
  task automatic xfer(input logic [23:0] tx, input int n,
      output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk_sys) cs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = n - 1; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rx = {rx[14:0], miso};
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

// [touch_panel_direct_conversion_test.sv]
`timescale 1ns/1ps
module touch_panel_direct_conversion_test;
  import tpd_pkg::*;
  typedef struct {
    logic [7:0] mode;
    logic [7:0] dep;
    logic [7:0] cmd;
    logic [6:0] a;
    logic [15:0] exp;
    logic [15:0] n;
  } tpd_row_t;
  logic clk_sys, resetn = 0, sclk, cs_n, mosi, miso, touch_irq_n;
  logic touch_det = 0, adc_done = 0, adc_start, pullup_en;
  logic drive_en, oe;
  logic [2:0] psel;
  logic [ADC_W-1:0] adc_data = 12'h000;
  logic [15:0] d, junk;
  logic [ADC_W-1:0] smp [4] = '{12'h804, 12'h100, 12'hF00, 12'h400};
  int fails = 0, total_checks = 0, si = 0, lat = 3, fe_cnt = 0;
  tpd_row_t rows [10] = '{
    '{8'h00, 8'h00, 8'h78, 7'h52, 16'h8040, 16'h0001},
    '{8'h03, 8'h01, 8'h78, 7'h52, 16'h6020, 16'h0004},
    '{8'h03, 8'h02, 8'h78, 7'h52, 16'h6020, 16'h0008},
    '{8'h03, 8'h03, 8'h78, 7'h52, 16'h6020, 16'h0010},
    '{8'h02, 8'h01, 8'h78, 7'h52, 16'h7010, 16'h0004},
    '{8'h02, 8'h0C, 8'h7A, 7'h53, 16'h7014, 16'h0010},
    '{8'h04, 8'h10, 8'h7C, 7'h54, 16'h7018, 16'h0004},
    '{8'h04, 8'h01, 8'h78, 7'h52, 16'h8040, 16'h0001},
    '{8'h10, 8'h00, 8'h78, 7'h52, 16'h8000, 16'h0001},
    '{8'h00, 8'h00, 8'h76, 7'h56, 16'h8040, 16'h0001}};

  tpd_host host (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso));
  tpd_ctrl #(.MAX_SAMP(16)) DUT (.clk_sys(clk_sys), .resetn(resetn),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(oe),
    .touch_irq_n(touch_irq_n), .touch_det(touch_det),
    .adc_done(adc_done), .adc_data(adc_data), .adc_start(adc_start),
    .pullup_en(pullup_en), .panel_drive_en(drive_en), .panel_sel(psel));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////
  // Front end: one sample per start, after lat cycles
  always @(posedge clk_sys) begin
    adc_done <= 1'b0;
    if (adc_start) fe_cnt <= lat;
    else if (fe_cnt == 1) begin
      adc_done <= 1'b1;
      adc_data <= smp[si % 4];
      si <= si + 1;
      fe_cnt <= 0;
    end else if (fe_cnt > 1) fe_cnt <= fe_cnt - 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    host.xfer({8'h00, a, 1'b0, v}, 16, junk);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    host.xfer({a, 1'b1, 16'h0000}, 24, v);
  endtask
  task automatic cmd(input logic [7:0] c);
    si = 0;
    host.xfer({16'h0000, c}, 8, junk);
  endtask
  task automatic rdw(input logic [6:0] a, output logic [15:0] v);
    for (int k = 0; k < 40; k++) begin
      rd(a, v);
      if (v !== WORD_BUSY) break;
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({15'h0000, touch_irq_n}, 16'h0001);
    chk({15'h0000, pullup_en}, 16'h0001);
    chk({14'h0000, drive_en, oe}, 16'h0000);
    rd(ADDR_MODE, d);
    chk(d, 16'h0000);
    rd(7'h20, d);
    chk(d, 16'h0000);
    touch_det <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk({15'h0000, touch_irq_n}, 16'h0000);
    foreach (rows[i]) begin
      wr(ADDR_MODE, rows[i].mode);
      wr(ADDR_AVG, rows[i].dep);
      cmd(rows[i].cmd);
      rdw(rows[i].a, d);
      chk(d, rows[i].exp);
      chk(16'(si), rows[i].n);
    end
    chk({15'h0000, touch_irq_n}, 16'h0000);
    rd(ADDR_STATUS, d);
    chk(d, 16'h6000);
    // Averaged auxiliary conversion
    wr(ADDR_AUXCFG, 8'h01);
    cmd({CMD_COMB, COMB_AUX, 1'b0});
    rdw(ADDR_RES + 7'h04, d);
    chk(d, 16'h7010);
    chk(16'(si), 16'h0004);
    // Setup, held measure, then an incompatible command
    cmd({CMD_SETUP, 2'h0, 1'b0});
    cmd({CMD_MEAS, 2'h0, 1'b1});
    rdw(ADDR_RES, d);
    chk(d, 16'h8040);
    chk({12'h000, drive_en, psel}, 16'h0008);
    cmd({CMD_COMB, 2'h0, 1'b0});
    chk({15'h0000, pullup_en}, 16'h0000);
    rd(ADDR_RES, d);
    chk(d, 16'h8040);
    // Combined run with a slow converter: all places stay busy
    wr(ADDR_MODE, 8'h00);
    lat = 300;
    cmd({CMD_COMB, 2'h2, 1'b0});
    rd(7'h55, d);
    chk(d, WORD_BUSY);
    repeat (100) @(posedge clk_sys);
    rd(ADDR_RES, d);
    chk(d, WORD_BUSY);
    lat = 3;
    for (int k = 0; k < 4; k++) begin
      rdw(ADDR_RES + 7'(k), d);
      chk(d, {smp[k], 2'(k), 2'h0});
    end
    // Edge mode: first, midpress, then release
    wr(ADDR_MODE, 8'h08);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) touch_det <= 1'b0;
      cmd({CMD_MEAS, 2'h0, 1'b0});
      rdw(ADDR_RES, d);
      chk(d, {smp[0], 2'h0, 2'(k)});
      if (k == 0) chk({15'h0000, pullup_en}, 16'h0000);
      if (k == 0) chk({15'h0000, touch_irq_n}, 16'h0001);
    end
    repeat (10) @(posedge clk_sys);
    chk({15'h0000, touch_irq_n}, 16'h0001);
    touch_det <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk({15'h0000, touch_irq_n}, 16'h0000);
    // Reset while idle in watch
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({15'h0000, pullup_en}, 16'h0001);
    rd(ADDR_MODE, d);
    chk(d, 16'h0000);
    rd(ADDR_RES, d);
    chk(d, 16'h0000);
    give_verdict;
  end
endmodule
